// ===== verilog/dpsc_top.sv
// dancer pid speed control core with axi4-lite register slave
// Operation
// (R1) action zero or select off: plain speed
// (R2) no select terminal: action value alone enables
// (R3) input function code 14 is select
// (R4) 40/42 reverse, 41/43 forward action
// (R5) 42/43 scale by main speed ratio
// (R6) ratio from terminal-2 bias and gain
// (R7) gain point 100%, bias point 0%
// (R8) nonzero bias below set: signal 0%
// (R9) select on: output freq becomes main; when not running the set frequency becomes main
// (R10) select off: continue at set frequency
// (R11) terminal 4 range 4-20mA/5V/10V
// (R12) upper flag unless limit 9999, code 15/115
// (R13) lower flag unless limit 9999, code 14/114
// (R14) direction flag on for forward, 16/116
// (R15) active flag during dancer control, 47/147
// (R16) code 100 or more inverts output
// (R17) pid terms; 0% bias, 100% gain
// (R18) set point 9999 means 50%
// (R19) configurer sets suspension level 9999
// (R20) thermistor mode removes terminal 2 main
// (R21) pid result added to main speed
// (R22) pid and flags update per period; the dir and active flags update every clock
`timescale 1ns/1ps
`default_nettype none
module dpsc_top
  import dpsc_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYC
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // drive side
  input  wire logic [NIN-1:0] input_terminals,
  input  wire logic [11:0] terminal4_adc,
  input  wire logic [15:0] terminal2_freq,
  input  wire logic [15:0] output_frequency,
  input  wire logic        running,
  input  wire logic        forward_rotation,
  output logic [15:0]      frequency_command,
  output logic [NOUT-1:0]  output_terminals
);

  // register file
  logic [7:0]  action, range_sel;
  logic [7:0]  insel [NIN];
  logic [7:0]  outsel [NOUT];
  logic [15:0] uplim, lolim, setpt, pband, itime, dtime;
  logic [15:0] biasf, gainf, therm, mainsp, susp;
  logic [7:0]  next_action, next_range;
  logic [7:0]  next_insel [NIN];
  logic [7:0]  next_outsel [NOUT];
  logic [15:0] next_uplim, next_lolim, next_setpt, next_pband;
  logic [15:0] next_itime, next_dtime, next_biasf, next_gainf;
  logic [15:0] next_therm, next_mainsp, next_susp;
  logic        aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // control state
  logic [31:0] tick_cnt, next_tick_cnt;
  logic        dancer_on, next_dancer_on;
  logic [15:0] main_cmd, next_main_cmd;
  logic [15:0] meas, next_meas;
  logic signed [31:0] integ, next_integ;
  logic signed [17:0] prev_err, next_prev_err;
  logic [15:0] next_fcmd;
  dpsc_flags_t flags, next_flags;
  logic [NOUT-1:0] next_outs;

  // map a code to flag value with optional inversion
  function automatic logic route_flag(input logic [7:0] code,
                                      input dpsc_flags_t f);
    logic [7:0] base;
    logic       v;
    base = (code >= OUT_NEG) ? code - OUT_NEG : code;
    case (base)
      OUT_UPPER:  v = f.upper;
      OUT_LOWER:  v = f.lower;
      OUT_DIR:    v = f.dir;
      OUT_ACTIVE: v = f.active;
      default:    v = 1'b0;
    endcase
    return (code >= OUT_NEG) ? ~v : v; // [R16]
  endfunction

  // percent in tenths from frequency over bias..gain span
  function automatic logic [15:0] freq_pct(input logic [15:0] f,
                                           input logic [15:0] b,
                                           input logic [15:0] g);
    logic [31:0] num;
    if (f <= b || g <= b)
      return 16'h0000; // [R7] [R8]
    if (f >= g)
      return PCT_FULL; // [R7]
    num = 32'(f - b) * 32'(PCT_FULL);
    return 16'(num / 32'(g - b));
  endfunction

  // clamp a signed tenths-of-percent value to plus or minus full scale
  function automatic logic signed [31:0] clamp_pct(
    input logic signed [31:0] v);
    logic signed [31:0] lim;
    lim = $signed(32'(PCT_FULL));
    if (v > lim)
      return lim;
    if (v < -lim)
      return -lim;
    return v;
  endfunction

  // ---- bus slave
  always_comb
  begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    next_action  = action;
    next_range   = range_sel;
    next_insel   = insel;
    next_outsel  = outsel;
    next_uplim   = uplim;
    next_lolim   = lolim;
    next_setpt   = setpt;
    next_pband   = pband;
    next_itime   = itime;
    next_dtime   = dtime;
    next_biasf   = biasf;
    next_gainf   = gainf;
    next_therm   = therm;
    next_mainsp  = mainsp;
    next_susp    = susp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (aw_hold && w_hold && !s_axi_bvalid)
    begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (aw_addr)
        A_ACTION: next_action = w_data[7:0];
        A_INSEL:  for (int i = 0; i < NIN; i++)
                    next_insel[i] = (w_data[7:0] == 8'(i))
                                    ? w_data[15:8] : insel[i];
        A_OUTSEL: for (int i = 0; i < NOUT; i++)
                    next_outsel[i] = (w_data[7:0] == 8'(i))
                                     ? w_data[15:8] : outsel[i];
        A_RANGE:  next_range  = w_data[7:0];
        A_UPLIM:  next_uplim  = w_data[15:0];
        A_LOLIM:  next_lolim  = w_data[15:0];
        A_SETPT:  next_setpt  = w_data[15:0];
        A_PBAND:  next_pband  = w_data[15:0];
        A_ITIME:  next_itime  = w_data[15:0];
        A_DTIME:  next_dtime  = w_data[15:0];
        A_BIASF:  next_biasf  = w_data[15:0];
        A_GAINF:  next_gainf  = w_data[15:0];
        A_THERM:  next_therm  = w_data[15:0];
        A_MAINSP: next_mainsp = w_data[15:0];
        A_SUSP:   next_susp   = w_data[15:0];
        default:  next_bresp  = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        A_ACTION: next_rdata[7:0]  = action;
        A_RANGE:  next_rdata[7:0]  = range_sel;
        A_UPLIM:  next_rdata[15:0] = uplim;
        A_LOLIM:  next_rdata[15:0] = lolim;
        A_SETPT:  next_rdata[15:0] = setpt;
        A_PBAND:  next_rdata[15:0] = pband;
        A_ITIME:  next_rdata[15:0] = itime;
        A_DTIME:  next_rdata[15:0] = dtime;
        A_BIASF:  next_rdata[15:0] = biasf;
        A_GAINF:  next_rdata[15:0] = gainf;
        A_THERM:  next_rdata[15:0] = therm;
        A_MAINSP: next_rdata[15:0] = mainsp;
        A_SUSP:   next_rdata[15:0] = susp;
        A_STATUS: next_rdata = {12'h000, meas, dancer_on,
                                flags.upper, flags.lower,
                                flags.active};
        A_FCMD:   next_rdata[15:0] = frequency_command;
        A_INSEL, A_OUTSEL: next_rdata = 32'h0000_0000;
        default:  next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      action        <= ACT_OFF;
      range_sel     <= {6'h00, RNG_4_20MA}; // [R11]
      for (int i = 0; i < NIN; i++)
        insel[i] <= 8'h00;
      for (int i = 0; i < NOUT; i++)
        outsel[i] <= 8'h00;
      uplim  <= VAL_NONE;
      lolim  <= VAL_NONE;
      setpt  <= VAL_NONE;
      pband  <= 16'h0064;
      itime  <= 16'h000a;
      dtime  <= VAL_NONE;
      biasf  <= 16'h0000;
      gainf  <= GAIN_RST;
      therm  <= VAL_NONE;
      mainsp <= 16'h0000;
      susp   <= VAL_NONE;
    end
    else
    begin
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      s_axi_awready <= !next_aw_hold && !s_axi_awready;
      s_axi_wready  <= !next_w_hold && !s_axi_wready;
      s_axi_arready <= !next_rvalid && !s_axi_arready;
      action <= next_action;
      range_sel <= next_range;
      insel  <= next_insel;
      outsel <= next_outsel;
      uplim  <= next_uplim;
      lolim  <= next_lolim;
      setpt  <= next_setpt;
      pband  <= next_pband;
      itime  <= next_itime;
      dtime  <= next_dtime;
      biasf  <= next_biasf;
      gainf  <= next_gainf;
      therm  <= next_therm;
      mainsp <= next_mainsp;
      susp   <= next_susp;
    end
  end

  // ---- control
  logic dancer_mode, sel_assigned, sel_level, want_on, tick, rev_act;
  logic ratio_mode, t2_main;
  logic [15:0] sp_pct, main_src, ratio;
  logic [15:0] raw_meas;
  logic signed [17:0] err;
  logic signed [31:0] pid_pct, pid_hz;
  logic signed [31:0] sum;

  always_comb
  begin
    dancer_mode = (action >= ACT_REV_FIX) && (action <= ACT_FWD_RAT);
    rev_act     = (action == ACT_REV_FIX) || (action == ACT_REV_RAT); // [R4]
    ratio_mode  = (action == ACT_REV_RAT) || (action == ACT_FWD_RAT); // [R5]
    sel_assigned = 1'b0;
    sel_level    = 1'b0;
    for (int i = 0; i < NIN; i++)
      if (insel[i] == IN_PID_SEL) // [R3]
      begin
        sel_assigned = 1'b1;
        sel_level    = sel_level | input_terminals[i];
      end
    want_on = dancer_mode && (!sel_assigned || sel_level); // [R1] [R2]
    tick    = (tick_cnt >= 32'(PERIOD - 1)); // [R22]
    t2_main = (therm == VAL_NONE); // [R20]
    main_src = t2_main ? terminal2_freq : mainsp;
    // measured value per range selection [R11]
    case (range_sel[1:0])
      RNG_4_20MA: raw_meas = (terminal4_adc <= ADC_4MA) ? 16'h0000 :
        16'((32'(terminal4_adc - ADC_4MA) * 32'(PCT_FULL))
            / 32'(ADC_FULL - ADC_4MA));
      RNG_0_5V:   raw_meas = (terminal4_adc >= ADC_HALF) ? PCT_FULL :
        16'((32'(terminal4_adc) * 32'(PCT_FULL)) / 32'(ADC_HALF));
      default:    raw_meas =
        16'((32'(terminal4_adc) * 32'(PCT_FULL)) / 32'(ADC_FULL));
    endcase
    sp_pct = (setpt == VAL_NONE) ? PCT_HALF : setpt; // [R18]
    err = rev_act ? 18'(sp_pct) - 18'(meas) : 18'(meas) - 18'(sp_pct);
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    next_dancer_on = want_on;
    next_main_cmd  = main_cmd;
    if (want_on && !dancer_on)
      next_main_cmd = running ? output_frequency : main_src; // [R9]
    else if (!want_on)
      next_main_cmd = main_src; // [R10]
    next_meas = tick ? raw_meas : meas;
    next_integ = integ;
    next_prev_err = prev_err;
    // pid in tenths of percent, signed so negative error divides right
    pid_pct = clamp_pct((32'(err) * $signed(32'(PCT_FULL)))
                        / $signed(32'(pband | 16'h1))
                        + integ
                        + ((dtime == VAL_NONE) ? 32'sh0 :
                           32'(err - prev_err) * $signed(32'(dtime))));
    if (tick && dancer_on)
    begin
      next_integ = clamp_pct(integ + 32'(err)
                             / $signed(32'(itime | 16'h1)));
      next_prev_err = err;
    end
    else if (!dancer_on)
    begin
      next_integ = 32'sh0;
      next_prev_err = 18'sh0;
    end
    pid_hz = (pid_pct * $signed(32'(gainf - biasf)))
           / $signed(32'(PCT_FULL)); // [R17]
    ratio = freq_pct(main_cmd, biasf, gainf); // [R6]
    if (ratio_mode)
      pid_hz = (pid_hz * $signed(32'(ratio)))
             / $signed(32'(PCT_FULL)); // [R5]
    sum = $signed(32'(main_cmd)) + pid_hz; // [R21]
    if (sum < 0)
      sum = 32'sh0;
    next_fcmd = frequency_command;
    if (tick)
      next_fcmd = dancer_on ? sum[15:0] : main_cmd; // [R1] [R22]
    next_flags = flags;
    if (tick)
    begin
      next_flags.upper = dancer_mode && uplim != VAL_NONE
                         && raw_meas > uplim; // [R12]
      next_flags.lower = dancer_mode && lolim != VAL_NONE
                         && raw_meas < lolim; // [R13]
    end
    next_flags.dir    = running && forward_rotation; // [R14]
    next_flags.active = dancer_on; // [R15]
    for (int i = 0; i < NOUT; i++)
      next_outs[i] = route_flag(outsel[i], next_flags); // [R16]
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt          <= 32'h0;
      dancer_on         <= 1'b0;
      main_cmd          <= 16'h0000;
      meas              <= 16'h0000;
      integ             <= 32'sh0;
      prev_err          <= 18'sh0;
      frequency_command <= 16'h0000;
      flags             <= '0;
      output_terminals  <= '0;
    end
    else
    begin
      tick_cnt          <= next_tick_cnt;
      dancer_on         <= next_dancer_on;
      main_cmd          <= next_main_cmd;
      meas              <= next_meas;
      integ             <= next_integ;
      prev_err          <= next_prev_err;
      frequency_command <= next_fcmd;
      flags             <= next_flags;
      output_terminals  <= next_outs;
    end
  end

  // ---- checks
  off_plain_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !dancer_mode |=> !dancer_on) // [R1]
    else $error("dancer on while action off");
  sel_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (sel_assigned && !sel_level) |=> !dancer_on) // [R3]
    else $error("dancer on with select off");
  noassign_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (dancer_mode && !sel_assigned) |=> dancer_on) // [R2]
    else $error("dancer off without select terminal");
  adopt_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (want_on && !dancer_on && running)
    |=> main_cmd == $past(output_frequency)) // [R9]
    else $error("main command not adopted");
  upper_none_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (uplim == VAL_NONE && tick) |=> !flags.upper) // [R12]
    else $error("upper flag with limit disabled");
  lower_none_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (lolim == VAL_NONE && tick) |=> !flags.lower) // [R13]
    else $error("lower flag with limit disabled");
  active_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
    dancer_on |=> flags.active) // [R15]
    else $error("active flag missing");
  hold_cmd_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !tick |=> $stable(frequency_command)) // [R22]
    else $error("command moved between updates");
endmodule
`default_nettype wire

// ===== verilog/dpsc_pkg.sv
// package for dancer pid speed control: register map, fields, constants
package dpsc_pkg;
  // register byte offsets
  localparam logic [7:0] A_ACTION = 8'h00;
  localparam logic [7:0] A_INSEL  = 8'h04;
  localparam logic [7:0] A_OUTSEL = 8'h08;
  localparam logic [7:0] A_RANGE  = 8'h0c;
  localparam logic [7:0] A_UPLIM  = 8'h10;
  localparam logic [7:0] A_LOLIM  = 8'h14;
  localparam logic [7:0] A_SETPT  = 8'h18;
  localparam logic [7:0] A_PBAND  = 8'h1c;
  localparam logic [7:0] A_ITIME  = 8'h20;
  localparam logic [7:0] A_DTIME  = 8'h24;
  localparam logic [7:0] A_BIASF  = 8'h28;
  localparam logic [7:0] A_GAINF  = 8'h2c;
  localparam logic [7:0] A_THERM  = 8'h30;
  localparam logic [7:0] A_MAINSP = 8'h34;
  localparam logic [7:0] A_STATUS = 8'h38;
  localparam logic [7:0] A_FCMD   = 8'h3c;
  localparam logic [7:0] A_SUSP   = 8'h40;
  // codes
  localparam logic [7:0]  ACT_OFF      = 8'h00;
  localparam logic [7:0]  ACT_REV_FIX  = 8'h28;
  localparam logic [7:0]  ACT_FWD_FIX  = 8'h29;
  localparam logic [7:0]  ACT_REV_RAT  = 8'h2a;
  localparam logic [7:0]  ACT_FWD_RAT  = 8'h2b;
  localparam logic [7:0]  IN_PID_SEL   = 8'h0e;
  localparam logic [7:0]  OUT_UPPER    = 8'h0f;
  localparam logic [7:0]  OUT_LOWER    = 8'h0e;
  localparam logic [7:0]  OUT_DIR      = 8'h10;
  localparam logic [7:0]  OUT_ACTIVE   = 8'h2f;
  localparam logic [7:0]  OUT_NEG      = 8'h64;
  localparam logic [15:0] VAL_NONE     = 16'h270f;
  localparam logic [15:0] PCT_FULL     = 16'h03e8;
  localparam logic [15:0] PCT_HALF     = 16'h01f4;
  localparam logic [15:0] GAIN_RST     = 16'h1388;
  localparam logic [1:0]  RNG_4_20MA   = 2'h0;
  localparam logic [1:0]  RNG_0_5V     = 2'h1;
  localparam logic [1:0]  RNG_0_10V    = 2'h2;
  localparam logic [11:0] ADC_FULL     = 12'hfff;
  localparam logic [11:0] ADC_4MA      = 12'h333;
  localparam logic [11:0] ADC_HALF     = 12'h7ff;
  localparam int          NIN          = 5;
  localparam int          NOUT         = 3;
  // control period
  localparam int          PERIOD_US    = 1000;
  localparam int          CLK_MHZ      = 100;
  localparam int          PERIOD_CYC   = PERIOD_US * CLK_MHZ;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef struct packed {
    logic upper;
    logic lower;
    logic dir;
    logic active;
  } dpsc_flags_t;
endpackage

// ===== verif/dpsc_dancer.sv
// dancer position detector and drive feedback model
`timescale 1ns/1ps
`default_nettype none
module dpsc_dancer
#(
  parameter int LAG = 1
)(
  // clock
  input  wire logic        core_clk,
  // commanded state
  input  wire logic [11:0] pos,
  input  wire logic [15:0] speed,
  input  wire logic        run,
  input  wire logic        fwd,
  // drive side
  output logic [11:0]      terminal4_adc,
  output logic [15:0]      terminal2_freq,
  output logic [15:0]      output_frequency,
  output logic             running,
  output logic             forward_rotation
);
  int cnt = 0;
  // lag above one models a slow detector
  always @(posedge core_clk)
  begin
    cnt <= (cnt + 1 >= LAG) ? 0 : cnt + 1;
    if (cnt == 0)
    begin
      terminal4_adc <= pos;
      terminal2_freq <= speed;
      output_frequency <= speed;
      running <= run;
      forward_rotation <= run & fwd;
    end
  end
endmodule
`default_nettype wire

// ===== verif/dpsc_top_test.sv
// self-checking bench for the dancer pid speed control block
`timescale 1ns/1ps
`default_nettype none
module dpsc_top_test;
  import dpsc_pkg::*;
  localparam int PER = 16;
  logic           core_clk = 1'b0;
  logic           rstn = 1'b0;
  logic [7:0]     s_axi_awaddr = 8'h00;
  logic           s_axi_awvalid = 1'b0;
  logic           s_axi_awready;
  logic [31:0]    s_axi_wdata = 32'h0;
  logic [3:0]     s_axi_wstrb = 4'hf;
  logic           s_axi_wvalid = 1'b0;
  logic           s_axi_wready;
  logic [1:0]     s_axi_bresp;
  logic           s_axi_bvalid;
  logic           s_axi_bready = 1'b0;
  logic [7:0]     s_axi_araddr = 8'h00;
  logic           s_axi_arvalid = 1'b0;
  logic           s_axi_arready;
  logic [31:0]    s_axi_rdata;
  logic [1:0]     s_axi_rresp;
  logic           s_axi_rvalid;
  logic           s_axi_rready = 1'b0;
  logic [NIN-1:0] input_terminals = '0;
  logic [11:0]    t4;
  logic [11:0]    pos = 12'h000;
  logic [15:0]    t2;
  logic [15:0]    ofreq;
  logic [15:0]    fcmd;
  logic [15:0]    speed = 16'h1388;
  logic           run = 1'b0;
  logic           fwd = 1'b0;
  logic           running;
  logic           fwd_rot;
  logic [NOUT-1:0] outs;
  logic [31:0]    rd;
  logic [1:0]     rs;
  logic [7:0]     acts [4] = '{ACT_REV_FIX, ACT_FWD_FIX, ACT_REV_RAT,
                               ACT_FWD_RAT};
  int             n_fail = 0;
  int             total_checks = 0;
  int             cyc = 0;

  dpsc_top #(.PERIOD(PER)) i_dpsc_top (.core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .input_terminals(input_terminals),
    .terminal4_adc(t4), .terminal2_freq(t2), .output_frequency(ofreq),
    .running(running), .forward_rotation(fwd_rot),
    .frequency_command(fcmd), .output_terminals(outs));

  dpsc_dancer #(.LAG(2)) i_dpsc_dancer (.core_clk(core_clk), .pos(pos),
    .speed(speed), .run(run), .fwd(fwd), .terminal4_adc(t4),
    .terminal2_freq(t2), .output_frequency(ofreq), .running(running),
    .forward_rotation(fwd_rot));

  always #5 core_clk = ~core_clk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    axw(a, d);
    chk("bresp", 32'(rs), 32'(RESP_OKAY));
  endtask

  // waits several control periods, then reads status
  task automatic settle;
    repeat (3 * PER) @(posedge core_clk);
    axr(A_STATUS);
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    axr(8'h44);
    chk("unmapped rresp", 32'(rs), 32'(RESP_SLVERR));
    chk("unmapped rdata", rd, 32'h0);
    axw(8'h44, 32'h1);
    chk("unmapped bresp", 32'(rs), 32'(RESP_SLVERR));
    cfg(A_SUSP, 32'(VAL_NONE));
    cfg(A_THERM, 32'(VAL_NONE));
    cfg(A_UPLIM, 32'(VAL_NONE));
    cfg(A_LOLIM, 32'(VAL_NONE));
    cfg(A_SETPT, 32'(VAL_NONE));
    cfg(A_ACTION, 32'(ACT_FWD_FIX));
    axr(A_ACTION);
    chk("action", rd, 32'h29);
    $display("test bus done");
    cfg(A_ACTION, 32'(ACT_OFF));
    cfg(A_OUTSEL, {16'h0, OUT_ACTIVE, 8'h00});
    run <= 1'b1;
    fwd <= 1'b1;
    settle();
    chk("fcmd off", 32'(fcmd), 32'h1388);
    chk("flags off", rd & 32'h7, 32'h0);
    chk("outs off", 32'(outs[0]), 32'h0);
    foreach (acts[i])
    begin
      cfg(A_ACTION, 32'(acts[i]));
      settle();
      chk("flags on", rd & 32'h7, 32'h1);
      chk("outs on", 32'(outs[0]), 32'h1);
    end
    cfg(A_OUTSEL, {16'h0, OUT_ACTIVE + OUT_NEG, 8'h00});
    settle();
    chk("outs neg", 32'(outs[0]), 32'h0);
    $display("test modes done");
    cfg(A_INSEL, {16'h0, IN_PID_SEL, 8'h01});
    settle();
    chk("sel off", rd & 32'h1, 32'h0);
    chk("fcmd sel off", 32'(fcmd), 32'h1388);
    input_terminals[1] <= 1'b1;
    settle();
    chk("sel on", rd & 32'h1, 32'h1);
    $display("test select done");
    for (int r = 0; r < 3; r++)
    begin
      cfg(A_RANGE, r);
      pos <= ADC_FULL;
      settle();
      chk("meas full", 32'(rd[19:4]), 32'(PCT_FULL));
      pos <= (r == 0) ? ADC_4MA : 12'h000;
      settle();
      chk("meas zero", 32'(rd[19:4]), 32'h0);
    end
    $display("test range done");
    pos <= ADC_FULL;
    cfg(A_ACTION, 32'(ACT_FWD_FIX));
    settle();
    chk("fcmd fwd fix", 32'(fcmd), 32'h2710);
    cfg(A_ACTION, 32'(ACT_REV_FIX));
    settle();
    chk("fcmd rev fix", 32'(fcmd), 32'h0);
    input_terminals[1] <= 1'b0;
    speed <= 16'h09c4;
    settle();
    chk("fcmd set freq", 32'(fcmd), 32'h09c4);
    cfg(A_ACTION, 32'(ACT_FWD_RAT));
    input_terminals[1] <= 1'b1;
    settle();
    chk("fcmd fwd ratio", 32'(fcmd), 32'h1388);
    cfg(A_ACTION, 32'(ACT_FWD_FIX));
    settle();
    chk("fcmd fwd fix half", 32'(fcmd), 32'h1d4c);
    speed <= 16'h1388;
    $display("test dancer done");
    cfg(A_UPLIM, 32'h0258);
    cfg(A_LOLIM, 32'h0190);
    cfg(A_OUTSEL, {16'h0, OUT_UPPER, 8'h01});
    cfg(A_OUTSEL, {16'h0, OUT_LOWER, 8'h02});
    pos <= ADC_FULL;
    settle();
    chk("flags high", rd & 32'h7, 32'h5);
    chk("outs high", 32'(outs[2:1]), 32'h1);
    pos <= 12'h000;
    settle();
    chk("flags low", rd & 32'h7, 32'h3);
    chk("outs low", 32'(outs[2:1]), 32'h2);
    cfg(A_OUTSEL, {16'h0, OUT_LOWER + OUT_NEG, 8'h02});
    settle();
    chk("outs low neg", 32'(outs[2]), 32'h0);
    cfg(A_LOLIM, 32'(VAL_NONE));
    settle();
    chk("lower none", rd & 32'h7, 32'h1);
    pos <= ADC_FULL;
    cfg(A_UPLIM, 32'(VAL_NONE));
    settle();
    chk("upper none", rd & 32'h7, 32'h1);
    $display("test limits done");
    cfg(A_OUTSEL, {16'h0, OUT_DIR, 8'h00});
    settle();
    chk("dir fwd", 32'(outs[0]), 32'h1);
    fwd <= 1'b0;
    settle();
    chk("dir rev", 32'(outs[0]), 32'h0);
    cfg(A_OUTSEL, {16'h0, OUT_DIR + OUT_NEG, 8'h00});
    settle();
    chk("dir rev neg", 32'(outs[0]), 32'h1);
    $display("test direction done");
    cfg(A_ACTION, 32'(ACT_OFF));
    cfg(A_MAINSP, 32'h0bb8);
    cfg(A_THERM, 32'h0);
    settle();
    chk("fcmd therm", 32'(fcmd), 32'h0bb8);
    cfg(A_THERM, 32'(VAL_NONE));
    settle();
    chk("fcmd t2", 32'(fcmd), 32'h1388);
    $display("test thermistor done");
    finish_test();
  end
endmodule
`default_nettype wire
